// *** verilog/timer_pair_pkg.sv ***
// Shared constants and types for the cascadable timer/counter pair.
`default_nettype none
package timer_pair_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock rates. The low-frequency clock is made by dividing pclk.
   localparam int unsigned PCLK_HZ = 250_000_000;
   localparam int unsigned FS_HZ = 32_768;
   localparam int unsigned FS_DIVIDE = PCLK_HZ / FS_HZ;

   ////////////////////////////////////////////////////////////////////////////////
   // Register byte offsets on the APB.
   localparam logic [7:0] ADDR_CTRL_LO = 8'h00;
   localparam logic [7:0] ADDR_CTRL_HI = 8'h04;
   localparam logic [7:0] ADDR_CMP_LO = 8'h08;
   localparam logic [7:0] ADDR_CMP_HI = 8'h0c;
   localparam logic [7:0] ADDR_DUTY_LO = 8'h10;
   localparam logic [7:0] ADDR_DUTY_HI = 8'h14;
   localparam logic [7:0] ADDR_CONFIG = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1c;

   // Field positions in counter_control_reg.
   localparam int CTRL_FF_BIT = 7;
   localparam int CTRL_CLK_LSB = 4;
   localparam int CTRL_RUN_BIT = 3;
   localparam int CTRL_MODE_LSB = 0;
   localparam int MODE_WIDE_BIT = 2;
   // Field positions in the configuration register.
   localparam int CFG_SLOW_BIT = 0;
   localparam int CFG_TAP_BIT = 1;

   // Reset values.
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CMP_RESET = 8'hff;
   localparam logic [7:0] DUTY_RESET = 8'h00;
   localparam logic [1:0] CONFIG_RESET = 2'h0;

   // Operating modes of operating_mode_field.
   localparam logic [2:0] MODE_TIMER8 = 3'h0;
   localparam logic [2:0] MODE_DIVIDER = 3'h1;

   // Source clock selections.
   localparam logic [2:0] CLK_SLOWEST = 3'h0;
   localparam logic [2:0] CLK_FC_DIV128 = 3'h1;
   localparam logic [2:0] CLK_FC_DIV32 = 3'h2;
   localparam logic [2:0] CLK_FC_DIV8 = 3'h3;
   localparam logic [2:0] CLK_FS = 3'h4;
   localparam logic [2:0] CLK_FC_DIV2 = 3'h5;
   localparam logic [2:0] CLK_FC = 3'h6;

   // Prescaler tap widths, as powers of two of fc or fs.
   localparam int TAP_FC_SLOWEST = 11;
   localparam int TAP_FC_128 = 7;
   localparam int TAP_FC_32 = 5;
   localparam int TAP_FC_8 = 3;
   localparam int TAP_FS_8 = 3;

   // One-cycle enables made by the prescaler.
   typedef struct packed {
      logic fc_div2;
      logic fc_div8;
      logic fc_div32;
      logic fc_div128;
      logic fc_div2048;
      logic fs;
      logic fs_div8;
   } taps_s;

endpackage : timer_pair_pkg
`default_nettype wire

// *** verilog/count_if.sv ***
// Carrier between the pair's control logic and one 8-bit up-counter.
`timescale 1ns/1ps
`default_nettype none
interface count_if;
   logic tick;
   logic clear;
   logic wrap;
   logic [7:0] count;
   modport owner(input tick, input clear, output wrap, output count);
   modport user(output tick, output clear, input wrap, input count);
endinterface : count_if
`default_nettype wire

// *** verilog/byte_counter.sv ***
// One 8-bit up-counter with clear priority and an overflow pulse.
`timescale 1ns/1ps
`default_nettype none
module byte_counter (
   input wire logic pclk,
   input wire logic presetn,
   count_if.owner cnt
);

   typedef struct packed {
      logic [7:0] count;
   } state_s;

   state_s cur;
   state_s next_cur;

   // Clear beats a tick, so a match never leaves a stray count behind.
   always_comb begin
      next_cur = cur;
      if (cnt.clear) begin
         next_cur.count = 8'h00;
      end else if (cnt.tick) begin
         next_cur.count = cur.count + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   // The wrap pulse clocks the upper byte when the pair is cascaded.
   assign cnt.count = cur.count;
   assign cnt.wrap = cnt.tick & ~cnt.clear & (cur.count == 8'hff);

endmodule : byte_counter
`default_nettype wire

// *** verilog/prescaler.sv ***
// Prescaler making fc and fs based one-cycle count enables.
`timescale 1ns/1ps
`default_nettype none
module prescaler
   import timer_pair_pkg::*;
#(
   parameter int unsigned FS_DIV = FS_DIVIDE
) (
   input wire logic pclk,
   input wire logic presetn,
   output taps_s taps
);

   typedef struct packed {
      logic [TAP_FC_SLOWEST-1:0] fc_cnt;
      logic [15:0] fs_cnt;
      logic [TAP_FS_8-1:0] fs8_cnt;
      taps_s taps;
   } state_s;

   localparam logic [15:0] FS_LAST = 16'(FS_DIV - 1);

   state_s cur;
   state_s next_cur;

   // fc enables fire when all low bits of the free-running count are ones; fs enables fire at FS_LAST.
   always_comb begin
      next_cur = cur;
      next_cur.fc_cnt = cur.fc_cnt + 11'h001;
      next_cur.taps.fc_div2 = &cur.fc_cnt[0];
      next_cur.taps.fc_div8 = &cur.fc_cnt[TAP_FC_8-1:0];
      next_cur.taps.fc_div32 = &cur.fc_cnt[TAP_FC_32-1:0];
      next_cur.taps.fc_div128 = &cur.fc_cnt[TAP_FC_128-1:0];
      next_cur.taps.fc_div2048 = &cur.fc_cnt;
      next_cur.taps.fs = (cur.fs_cnt == FS_LAST);
      next_cur.taps.fs_div8 = (cur.fs_cnt == FS_LAST) & (&cur.fs8_cnt);
      if (cur.fs_cnt == FS_LAST) begin
         next_cur.fs_cnt = 16'h0000;
         next_cur.fs8_cnt = cur.fs8_cnt + 3'h1;
      end else begin
         next_cur.fs_cnt = cur.fs_cnt + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign taps = cur.taps;

endmodule : prescaler
`default_nettype wire

// *** verilog/timer_pair.sv ***
// Top of the cascadable timer/counter pair with its APB register file.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Timer mode counts selected clock; on match interrupt, clear, keep counting.
// - Timer compare register has no shadow; writes act at once.
// - Event mode counts each falling edge of the event pin.
// - Event mode match interrupts and clears, then counts later edges.
// - Event compare register has no shadow; writes act at once.
// - Divider mode counts clock; match toggles flip-flop, clears, interrupts.
// - Divider pin always shows the inverse of the flip-flop.
// - Software presets the flip-flop only while the byte is stopped; reset clears it to 0.
// - Divider output is a 50% square wave, half period one interval.
// - Slow mode offers only fs/2^3, fs and pin sources.
// - In 16-bit modes the upper byte counts lower overflows.
// - Three-bit mode field selects 8-bit, divider, and 16-bit modes.
module timer_pair
   import timer_pair_pkg::*;
#(
   parameter int unsigned FS_DIV = FS_DIVIDE
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic event_input_pin_lo,
   input wire logic event_input_pin_hi,
   output logic divider_output_pin_lo,
   output logic divider_output_pin_hi,
   output logic match_interrupt_lo,
   output logic match_interrupt_hi
);

   ////////////////////////////////////////////////////////////////////////////////
   // State and sub-blocks.
   typedef struct packed {
      logic [7:0] ctrl_lo;
      logic [7:0] ctrl_hi;
      logic [7:0] cmp_lo;
      logic [7:0] cmp_hi;
      logic [7:0] duty_lo;
      logic [7:0] duty_hi;
      logic [1:0] config_bits;
      logic ff_lo;
      logic ff_hi;
      logic [2:0] sync_lo;
      logic [2:0] sync_hi;
      logic match_lo;
      logic match_hi;
      logic pin_lo;
      logic pin_hi;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } state_s;

   localparam state_s STATE_RESET = '{
      ctrl_lo: CTRL_RESET,
      ctrl_hi: CTRL_RESET,
      cmp_lo: CMP_RESET,
      cmp_hi: CMP_RESET,
      duty_lo: DUTY_RESET,
      duty_hi: DUTY_RESET,
      config_bits: CONFIG_RESET,
      pin_lo: 1'b1,
      pin_hi: 1'b1,
      default: '0
   };

   state_s cur;
   state_s next_cur;
   taps_s taps;
   logic tick_lo;
   logic tick_hi;
   logic clear_lo;
   logic clear_hi;

   count_if lo_if();
   count_if hi_if();

   prescaler #(
      .FS_DIV(FS_DIV)
   ) u_prescaler (
      .pclk(pclk),
      .presetn(presetn),
      .taps(taps)
   );

   byte_counter u_lower (
      .pclk(pclk),
      .presetn(presetn),
      .cnt(lo_if.owner)
   );

   byte_counter u_upper (
      .pclk(pclk),
      .presetn(presetn),
      .cnt(hi_if.owner)
   );

   assign lo_if.tick = tick_lo;
   assign lo_if.clear = clear_lo;
   assign hi_if.tick = tick_hi;
   assign hi_if.clear = clear_hi;

   ////////////////////////////////////////////////////////////////////////////////
   // Source clock choice for one byte.
   // In slow mode the fc taps are dead, so only fs based and pin sources count.
   function automatic logic pick_source(input logic [2:0] sel, input logic fell,
                                        input logic slow, input logic tap_fs,
                                        input taps_s t);
      logic hit;
      hit = 1'b0;
      case (sel)
         CLK_SLOWEST: hit = (slow | tap_fs) ? t.fs_div8 : t.fc_div2048;
         CLK_FC_DIV128: hit = ~slow & t.fc_div128;
         CLK_FC_DIV32: hit = ~slow & t.fc_div32;
         CLK_FC_DIV8: hit = ~slow & t.fc_div8;
         CLK_FS: hit = t.fs;
         CLK_FC_DIV2: hit = ~slow & t.fc_div2;
         CLK_FC: hit = ~slow;
         default: hit = fell;
      endcase
      return hit;
   endfunction : pick_source

   ////////////////////////////////////////////////////////////////////////////////
   // Counting, matching and the output flip-flops.
   logic wide;
   logic run_lo;
   logic run_hi;
   logic src_lo;
   logic src_hi;
   logic fell_lo;
   logic fell_hi;
   logic hit_lo;
   logic hit_hi;
   logic hit_wide;
   logic [15:0] count_wide;
   logic [15:0] cmp_wide;
   logic [2:0] mode_lo;
   logic [2:0] mode_hi;

   // Edge detection reads only the second and third synchroniser stages.
   assign fell_lo = cur.sync_lo[2] & ~cur.sync_lo[1];
   assign fell_hi = cur.sync_hi[2] & ~cur.sync_hi[1];
   assign mode_lo = cur.ctrl_lo[CTRL_MODE_LSB +: 3];
   assign mode_hi = cur.ctrl_hi[CTRL_MODE_LSB +: 3];
   assign wide = mode_hi[MODE_WIDE_BIT];
   assign count_wide = {hi_if.count, lo_if.count};
   assign cmp_wide = {cur.cmp_hi, cur.cmp_lo};

   // A byte runs only in the modes this block counts in; PWM and reserved stop it.
   always_comb begin
      run_lo = 1'b0;
      run_hi = 1'b0;
      if (wide) begin
         run_lo = cur.ctrl_hi[CTRL_RUN_BIT];
      end else begin
         run_lo = cur.ctrl_lo[CTRL_RUN_BIT] &
                  ((mode_lo == MODE_TIMER8) | (mode_lo == MODE_DIVIDER));
         run_hi = cur.ctrl_hi[CTRL_RUN_BIT] &
                  ((mode_hi == MODE_TIMER8) | (mode_hi == MODE_DIVIDER));
      end
   end

   // Compare values are read live from the registers, with no shadow stage.
   always_comb begin
      src_lo = pick_source(cur.ctrl_lo[CTRL_CLK_LSB +: 3], fell_lo,
                           cur.config_bits[CFG_SLOW_BIT], cur.config_bits[CFG_TAP_BIT],
                           taps);
      src_hi = pick_source(cur.ctrl_hi[CTRL_CLK_LSB +: 3], fell_hi,
                           cur.config_bits[CFG_SLOW_BIT], cur.config_bits[CFG_TAP_BIT],
                           taps);
      tick_lo = run_lo & src_lo;
      hit_wide = wide & tick_lo & ((count_wide + 16'h0001) == cmp_wide);
      hit_lo = ~wide & tick_lo & ((lo_if.count + 8'h01) == cur.cmp_lo);
      tick_hi = wide ? lo_if.wrap : (run_hi & src_hi);
      hit_hi = ~wide & tick_hi & ((hi_if.count + 8'h01) == cur.cmp_hi);
      clear_lo = ~run_lo | hit_lo | hit_wide;
      clear_hi = (wide ? ~run_lo : ~run_hi) | hit_hi | hit_wide;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state: synchronisers, flip-flops, pins, interrupts and the APB slave.
   logic acc;
   logic wr_now;
   logic mapped;
   logic [31:0] rd_word;

   assign acc = psel & penable;
   assign wr_now = acc & pwrite & cur.pready;

   // Address decode; unaligned or unknown offsets answer with an error.
   always_comb begin
      mapped = 1'b1;
      rd_word = 32'h0000_0000;
      if (paddr == ADDR_CTRL_LO) begin
         rd_word = {24'h00_0000, cur.ctrl_lo};
      end else if (paddr == ADDR_CTRL_HI) begin
         rd_word = {24'h00_0000, cur.ctrl_hi};
      end else if (paddr == ADDR_CMP_LO) begin
         rd_word = {24'h00_0000, cur.cmp_lo};
      end else if (paddr == ADDR_CMP_HI) begin
         rd_word = {24'h00_0000, cur.cmp_hi};
      end else if (paddr == ADDR_DUTY_LO) begin
         rd_word = {24'h00_0000, cur.duty_lo};
      end else if (paddr == ADDR_DUTY_HI) begin
         rd_word = {24'h00_0000, cur.duty_hi};
      end else if (paddr == ADDR_CONFIG) begin
         rd_word = {30'h0000_0000, cur.config_bits};
      end else if (paddr == ADDR_STATUS) begin
         rd_word = {14'h0000, cur.ff_hi, cur.ff_lo, hi_if.count, lo_if.count};
      end else begin
         mapped = 1'b0;
      end
   end

   always_comb begin
      next_cur = cur;
      next_cur.sync_lo = {cur.sync_lo[1:0], event_input_pin_lo};
      next_cur.sync_hi = {cur.sync_hi[1:0], event_input_pin_hi};

      // Divider mode toggles on each match, so each half period is one interval.
      if (~wide & (mode_lo == MODE_DIVIDER) & hit_lo) begin
         next_cur.ff_lo = ~cur.ff_lo;
      end
      if (~wide & (mode_hi == MODE_DIVIDER) & hit_hi) begin
         next_cur.ff_hi = ~cur.ff_hi;
      end

      // The match interrupt is a one-cycle pulse per compare match.
      next_cur.match_lo = hit_lo;
      next_cur.match_hi = hit_hi | hit_wide;

      // One wait cycle, then pready for exactly one cycle.
      next_cur.pready = acc & ~cur.pready;
      next_cur.pslverr = acc & ~cur.pready & ~mapped;
      if (acc & ~cur.pready & ~pwrite) begin
         next_cur.prdata = rd_word;
      end

      // Writes land on the edge that sees pready high.
      if (wr_now & mapped) begin
         if (paddr == ADDR_CTRL_LO) begin
            next_cur.ctrl_lo = pwdata[7:0];
            if (~cur.ctrl_lo[CTRL_RUN_BIT]) begin
               next_cur.ff_lo = pwdata[CTRL_FF_BIT];
            end
         end else if (paddr == ADDR_CTRL_HI) begin
            next_cur.ctrl_hi = pwdata[7:0];
            if (~cur.ctrl_hi[CTRL_RUN_BIT]) begin
               next_cur.ff_hi = pwdata[CTRL_FF_BIT];
            end
         end else if (paddr == ADDR_CMP_LO) begin
            next_cur.cmp_lo = pwdata[7:0];
         end else if (paddr == ADDR_CMP_HI) begin
            next_cur.cmp_hi = pwdata[7:0];
         end else if (paddr == ADDR_DUTY_LO) begin
            next_cur.duty_lo = pwdata[7:0];
         end else if (paddr == ADDR_DUTY_HI) begin
            next_cur.duty_hi = pwdata[7:0];
         end else if (paddr == ADDR_CONFIG) begin
            next_cur.config_bits = pwdata[1:0];
         end
      end

      // Pins are registered copies of the inverted next flip-flop level.
      next_cur.pin_lo = ~next_cur.ff_lo;
      next_cur.pin_hi = ~next_cur.ff_hi;
   end

   // Reset clears both flip-flops, so both divider pins start high.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= STATE_RESET;
      end else begin
         cur <= next_cur;
      end
   end

   assign prdata = cur.prdata;
   assign pready = cur.pready;
   assign pslverr = cur.pslverr;
   assign divider_output_pin_lo = cur.pin_lo;
   assign divider_output_pin_hi = cur.pin_hi;
   assign match_interrupt_lo = cur.match_lo;
   assign match_interrupt_hi = cur.match_hi;

endmodule : timer_pair
`default_nettype wire

// *** testbench/event_source.sv ***
// Pulse source model driving the two event pins of the timer pair.
`timescale 1ns/1ps
`default_nettype none
module event_source (
   input wire logic pclk,
   input wire logic [1:0] go,
   input wire logic [7:0] num,
   input wire logic [7:0] hold,
   output logic [1:0] event_pin,
   output logic busy
);
   logic [1:0] sel;
   initial begin
      event_pin = 2'b11;
      busy = 1'b0;
   end
   // The pins idle high as on a pulled-up line; each level lasts hold cycles, never under 2.
   always @(posedge pclk) begin
      if (go != 2'b00) begin
         sel = go;
         busy <= 1'b1;
         repeat (num) begin
            event_pin <= ~sel;
            repeat (hold) @(posedge pclk);
            event_pin <= 2'b11;
            repeat (hold) @(posedge pclk);
         end
         busy <= 1'b0;
      end
   end
endmodule : event_source
`default_nettype wire

// *** testbench/timer_pair_properties.sv ***
// Port-level checker for the timer pair.
`timescale 1ns/1ps
`default_nettype none
module timer_pair_properties
   import timer_pair_pkg::*;
#(
   parameter int unsigned FS_DIV = FS_DIVIDE
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic event_input_pin_lo,
   input wire logic event_input_pin_hi,
   input wire logic divider_output_pin_lo,
   input wire logic divider_output_pin_hi,
   input wire logic match_interrupt_lo,
   input wire logic match_interrupt_hi
);
   logic wr_lo;
   logic [7:0] ctrl;
   // Mirror of the lower control byte; a mode is only known once its write completes.
   assign wr_lo = psel && penable && pready && pwrite && paddr == ADDR_CTRL_LO;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RESET;
      end else if (wr_lo) begin
         ctrl <= pwdata[7:0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_READY_PULSE:
      assert property (pready |=> !pready) else $error("pready held too long");
   AST_READY_ANSWER:
      assert property (psel && penable && !pready |=> pready) else $error("no pready");
   AST_READY_CAUSE:
      assert property (pready |-> $past(psel && penable)) else $error("stray pready");
   AST_ERR_WITH_READY:
      assert property (pslverr |-> pready) else $error("pslverr without pready");
   AST_UNMAPPED_ZERO:
      assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
         else $error("refused read not zero");
   AST_PIN_CAUSE:
      assert property ($changed(divider_output_pin_lo) |-> match_interrupt_lo
         || $past(wr_lo) || $past(wr_lo, 2)) else $error("pin moved without cause");
   AST_DIV_TOGGLE:
      assert property (match_interrupt_lo && ctrl[2:0] == MODE_DIVIDER
         |-> $changed(divider_output_pin_lo)) else $error("divider match without toggle");
   AST_TIMER_STEADY:
      assert property (match_interrupt_lo && ctrl[2:0] == MODE_TIMER8
         |-> $stable(divider_output_pin_lo)) else $error("timer match moved pin");
   AST_STOP_SILENT:
      assert property (!ctrl[CTRL_RUN_BIT] && !$past(ctrl[CTRL_RUN_BIT])
         |-> !match_interrupt_lo) else $error("match while stopped");
endmodule : timer_pair_properties
bind timer_pair timer_pair_properties #(.FS_DIV(FS_DIV)) i_props (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .event_input_pin_lo(event_input_pin_lo), .event_input_pin_hi(event_input_pin_hi),
   .divider_output_pin_lo(divider_output_pin_lo),
   .divider_output_pin_hi(divider_output_pin_hi),
   .match_interrupt_lo(match_interrupt_lo), .match_interrupt_hi(match_interrupt_hi));
`default_nettype wire

// *** testbench/timer_pair_test.sv ***
// Self-checking bench for the timer pair driven over APB.
`timescale 1ns/1ps
`default_nettype none
module timer_pair_test
   import timer_pair_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, rd_err;
   logic [7:0] paddr, num, hold;
   logic [31:0] pwdata, prdata, rd_data;
   logic [1:0] ev, pin, irq, go;
   int errors, num_checks, cyc;
   timer_pair #(.FS_DIV(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .event_input_pin_lo(ev[0]),
      .event_input_pin_hi(ev[1]), .divider_output_pin_lo(pin[0]),
      .divider_output_pin_hi(pin[1]), .match_interrupt_lo(irq[0]),
      .match_interrupt_hi(irq[1]));
   event_source i_src (.pclk(pclk), .go(go), .num(num), .hold(hold), .event_pin(ev),
      .busy(busy));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, and a ceiling on run length so a hung handshake still ends the run.
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : check
   // One APB transfer; an idle edge follows so callers never reassign psel in one step.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check($sformatf("register %h", a), exp, rd_data);
   endtask : rd_chk
   // Cycles until the pin next changes or the next match pulse.
   task span(input int ch, input bit on_pin, output int n);
      logic v;
      v = pin[ch];
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while ((on_pin ? pin[ch] === v : irq[ch] !== 1'b1) && n < 2000);
   endtask : span
   task pulses(input int ch, input logic [7:0] k, input logic [7:0] h);
      num <= k;
      hold <= h;
      go <= 2'(1 << ch);
      @(posedge pclk);
      go <= 2'b00;
      do @(posedge pclk); while (busy !== 1'b0);
      repeat (6) @(posedge pclk);
   endtask : pulses
   task finish_test();
      if (errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset, register map, then each mode on both counters.
   initial begin
      logic [7:0] o;
      logic v;
      int n;
      {presetn, psel, penable, pwrite, paddr, pwdata, go, num, hold} = '0;
      {errors, num_checks, cyc} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("pins", 32'h0000_0003, 32'(pin));
      rd_chk(ADDR_CTRL_LO, 32'(CTRL_RESET));
      rd_chk(ADDR_CMP_HI, 32'(CMP_RESET));
      rd_chk(ADDR_DUTY_LO, 32'(DUTY_RESET));
      rd_chk(ADDR_CONFIG, 32'(CONFIG_RESET));
      rd_chk(ADDR_STATUS, 32'h0000_0000);
      apb(1'b1, 8'h09, 32'h0000_0007);
      check("refusal", 32'h0000_0001, 32'(rd_err));
      rd_chk(8'h20, 32'h0000_0000);
      check("refusal", 32'h0000_0001, 32'(rd_err));
      rd_chk(ADDR_CMP_LO, 32'(CMP_RESET));
      for (int ch = 0; ch < 2; ch++) begin
         o = 8'(4 * ch);
         apb(1'b1, ADDR_CMP_LO + o, 32'h0000_0005);
         apb(1'b1, ADDR_CTRL_LO + o, 32'h0000_0068);
         span(ch, 1'b0, n);
         span(ch, 1'b0, n);
         check("timer period", 32'd5, 32'(n));
         apb(1'b1, ADDR_CMP_LO + o, 32'h0000_0003);
         span(ch, 1'b0, n);
         span(ch, 1'b0, n);
         check("new period", 32'd3, 32'(n));
         apb(1'b1, ADDR_CTRL_LO + o, 32'h0000_0060);
         rd_chk(ADDR_STATUS, 32'h0000_0000);
         // No port latch sits between flip-flop and pin here, so none is set first.
         apb(1'b1, ADDR_CMP_LO + o, 32'h0000_0004);
         apb(1'b1, ADDR_CTRL_LO + o, 32'h0000_00e1);
         repeat (2) @(posedge pclk);
         check("preset pin", 32'h0000_0000, 32'(pin[ch]));
         rd_chk(ADDR_STATUS, 32'h0001_0000 << ch);
         apb(1'b1, ADDR_CTRL_LO + o, 32'h0000_00e9);
         span(ch, 1'b1, n);
         span(ch, 1'b1, n);
         check("half period", 32'd4, 32'(n));
         span(ch, 1'b1, n);
         check("half period", 32'd4, 32'(n));
         // A toggle can land on the same edge as the stop, so the level is taken after it.
         apb(1'b1, ADDR_CTRL_LO + o, 32'h0000_00e1);
         v = pin[ch];
         repeat (20) @(posedge pclk);
         check("stopped pin", 32'(v), 32'(pin[ch]));
         apb(1'b1, ADDR_CTRL_LO + o, 32'h0000_0061);
         repeat (2) @(posedge pclk);
         check("preset pin", 32'h0000_0001, 32'(pin[ch]));
         apb(1'b1, ADDR_CMP_LO + o, 32'h0000_0003);
         apb(1'b1, ADDR_CTRL_LO + o, 32'h0000_0078);
         pulses(ch, 8'd2, 8'd2);
         rd_chk(ADDR_STATUS, 32'h0000_0002 << (8 * ch));
         pulses(ch, 8'd1, 8'd5);
         rd_chk(ADDR_STATUS, 32'h0000_0000);
         apb(1'b1, ADDR_CMP_LO + o, 32'h0000_0001);
         pulses(ch, 8'd1, 8'd3);
         rd_chk(ADDR_STATUS, 32'h0000_0000);
         apb(1'b1, ADDR_CTRL_LO + o, 32'h0000_0070);
      end
      // Cascade: the lower clock select drives a 16-bit count of 0x0102 ticks.
      // Warm-up, 16-bit PWM and PPG stay unselected, so their limits hold.
      apb(1'b1, ADDR_CMP_LO, 32'h0000_0002);
      apb(1'b1, ADDR_CMP_HI, 32'h0000_0001);
      apb(1'b1, ADDR_CTRL_LO, 32'h0000_0063);
      apb(1'b1, ADDR_CTRL_HI, 32'h0000_000c);
      span(1, 1'b0, n);
      span(1, 1'b0, n);
      check("wide period", 32'd258, 32'(n));
      apb(1'b1, ADDR_CTRL_HI, 32'h0000_0000);
      rd_chk(ADDR_STATUS, 32'h0000_0000);
      apb(1'b1, ADDR_CONFIG, 32'h0000_0001);
      apb(1'b1, ADDR_CMP_LO, 32'h0000_00ff);
      apb(1'b1, ADDR_CTRL_LO, 32'h0000_0068);
      repeat (40) @(posedge pclk);
      rd_chk(ADDR_STATUS, 32'h0000_0000);
      apb(1'b1, ADDR_CTRL_LO, 32'h0000_0008);
      repeat (100) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      // The fs/2^3 tap fires every 32 cycles here, and about 102 edges pass before the read.
      check("slow count", 32'h0000_0001, 32'(rd_data[7:0] inside {[8'd3:8'd4]}));
      finish_test();
   end
endmodule : timer_pair_test
`default_nettype wire
